// ==== verilog/asbp_pkg.sv ====
// Shared constants and types for the asynchronous SRAM port controller
package asbp_pkg;

    // ==========================================================
    // Clock and widths
    localparam int CLK_PERIOD_NS = 10;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    localparam int LANE_W = 8;
    localparam int TMR_W = 4;

    // ==========================================================
    // Pin timing in ns (least times, rounded up to cycles)
    localparam int T_AA_NS = 45;
    localparam int T_PWE_NS = 35;
    localparam int T_SD_NS = 25;
    localparam int T_HZOE_NS = 18;
    localparam int T_R_NS = 45;

    localparam int RD_CYC = (T_AA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PWE_RAW = (T_PWE_NS > T_SD_NS) ? T_PWE_NS : T_SD_NS;
    localparam int WE_CYC = (PWE_RAW + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TURN_CYC = (T_HZOE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REC_CYC = (T_R_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Timer loads: a state lasts load value plus one cycle
    localparam logic [TMR_W-1:0] RD_LOAD = TMR_W'(RD_CYC - 1);
    localparam logic [TMR_W-1:0] WE_LOAD = TMR_W'(WE_CYC - 1);
    localparam logic [TMR_W-1:0] TURN_LOAD = TMR_W'(TURN_CYC - 1);
    localparam logic [TMR_W-1:0] REC_LOAD = TMR_W'(REC_CYC - 1);

    // ==========================================================
    // Pin reset, idle and byte-mode lane levels
    localparam logic [1:0] LANES_OFF_N = 2'h3;
    localparam logic [1:0] LANES_BYTE_N = 2'h0;
    localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;

    // ==========================================================
    // Controller states
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_RD_ACCESS = 7'h02,
        ST_WR_SETUP = 7'h04,
        ST_WR_PULSE = 7'h08,
        ST_WR_HOLD = 7'h10,
        ST_RETAIN = 7'h20,
        ST_RECOVER = 7'h40
    } asbp_state_type;

endpackage

// ==== verilog/asbp_tmr_if.sv ====
// Interface between the controller and its cycle timer
`timescale 1ns/1ps
interface asbp_tmr_if;
    import asbp_pkg::*;
    logic load;
    logic [TMR_W-1:0] load_val;
    logic expired;

    modport ctrl (output load, output load_val, input expired);
    modport timer (input load, input load_val, output expired);
endinterface

// ==== verilog/asbp_timer.sv ====
// Loadable down counter that times the read, write setup, write pulse and recovery phases
`timescale 1ns/1ps
module asbp_timer
    import asbp_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Controller side
    asbp_tmr_if.timer tmr
);

    logic [TMR_W-1:0] cnt_reg;
    logic [TMR_W-1:0] cnt_next;

    always_comb begin
        if (tmr.load) begin
            cnt_next = tmr.load_val;
        end else if (cnt_reg != '0) begin
            cnt_next = cnt_reg - TMR_W'(1);
        end else begin
            cnt_next = cnt_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign tmr.expired = (cnt_reg == '0);

endmodule

// ==== verilog/asbp_host.sv ====
// Host-side controller for an asynchronous byte-lane SRAM
`timescale 1ns/1ps

module asbp_host
    import asbp_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // User request port
    input wire logic req_i,
    input wire logic write_i,
    input wire logic [ADDR_W:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic [1:0] byte_en_i,
    input wire logic wide_mode_i,
    input wire logic retain_req_i,
    output logic ready_o,
    output logic done_o,
    output logic [DATA_W-1:0] rdata_o,
    output logic retain_ok_o,
    // Memory pins
    output logic select_low_active_n_o,
    output logic select_high_active_o,
    output logic write_n_o,
    output logic out_en_n_o,
    output logic upper_lane_n_o,
    output logic lower_lane_n_o,
    output logic [ADDR_W-1:0] addr_o,
    output logic extra_address_msb_o,
    output logic [DATA_W-1:0] data_o,
    output logic [1:0] data_oe_o,
    input wire logic [DATA_W-1:0] data_i
);

    // ==========================================================
    // Timer
    asbp_tmr_if tmr_bus ();

    asbp_timer u_timer (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .tmr(tmr_bus.timer)
    );

    // ==========================================================
    // State and latched request
    asbp_state_type state_reg, state_next;
    logic [ADDR_W:0] addr_reg, addr_next;
    logic [DATA_W-1:0] wdata_reg, wdata_next;
    logic [1:0] lanes_reg, lanes_next;
    logic wide_reg, wide_next;
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    logic done_reg, done_next;
    logic ready_reg, ready_next;
    logic retain_reg, retain_next;
    logic sel_n_reg, sel_n_next;
    logic sel_h_reg, sel_h_next;
    logic we_n_reg, we_n_next;
    logic oe_n_reg, oe_n_next;
    logic [1:0] lane_n_reg, lane_n_next;
    logic [1:0] doe_reg, doe_next;
    logic [1:0] rd_mask;
    logic tmr_load;
    logic [TMR_W-1:0] tmr_val;

    assign tmr_bus.load = tmr_load;
    assign tmr_bus.load_val = tmr_val;

    always_comb begin
        state_next = state_reg;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        lanes_next = lanes_reg;
        wide_next = wide_reg;
        rdata_next = rdata_reg;
        done_next = 1'b0;
        rd_mask = wide_reg ? lanes_reg : 2'h1;
        unique case (state_reg)
            ST_IDLE: begin
                if (retain_req_i) begin
                    state_next = ST_RETAIN;
                end else if (req_i) begin
                    addr_next = addr_i;
                    wdata_next = wdata_i;
                    lanes_next = byte_en_i;
                    wide_next = wide_mode_i;
                    if (wide_mode_i && byte_en_i == 2'h0) begin
                        // No lane: finish without touching the array
                        done_next = 1'b1;
                        if (!write_i) begin
                            rdata_next = DATA_ZERO;
                        end
                    end else if (write_i) begin
                        state_next = ST_WR_SETUP;
                    end else begin
                        state_next = ST_RD_ACCESS;
                    end
                end
            end
            ST_RD_ACCESS: begin
                if (tmr_bus.expired) begin
                    for (int i = 0; i < 2; i++) begin
                        rdata_next[i*LANE_W +: LANE_W] =
                            rd_mask[i] ? data_i[i*LANE_W +: LANE_W] : 8'h00;
                    end
                    done_next = 1'b1;
                    state_next = ST_IDLE;
                end
            end
            ST_WR_SETUP: begin
                if (tmr_bus.expired) begin
                    state_next = ST_WR_PULSE;
                end
            end
            ST_WR_PULSE: begin
                if (tmr_bus.expired) begin
                    state_next = ST_WR_HOLD;
                end
            end
            ST_WR_HOLD: begin
                done_next = 1'b1;
                state_next = ST_IDLE;
            end
            ST_RETAIN: begin
                if (!retain_req_i) begin
                    state_next = ST_RECOVER;
                end
            end
            ST_RECOVER: begin
                if (tmr_bus.expired) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase

        // Timer loads on entry to each timed phase
        tmr_load = (state_next != state_reg);
        unique case (state_next)
            ST_RD_ACCESS: tmr_val = RD_LOAD;
            ST_WR_SETUP: tmr_val = TURN_LOAD;
            ST_WR_PULSE: tmr_val = WE_LOAD;
            ST_RECOVER: tmr_val = REC_LOAD;
            default: tmr_val = '0;
        endcase

        // Pin levels follow the next state so they leave flip-flops
        ready_next = (state_next == ST_IDLE);
        retain_next = (state_next == ST_RETAIN);
        sel_n_next = 1'b1;
        sel_h_next = 1'b0;
        we_n_next = 1'b1;
        oe_n_next = 1'b1;
        lane_n_next = LANES_OFF_N;
        doe_next = 2'h0;
        if (state_next == ST_RD_ACCESS || state_next == ST_WR_SETUP ||
            state_next == ST_WR_PULSE || state_next == ST_WR_HOLD) begin
            sel_n_next = 1'b0;
            sel_h_next = 1'b1;
            lane_n_next = wide_next ? ~lanes_next : LANES_BYTE_N;
        end
        if (state_next == ST_RD_ACCESS) begin
            oe_n_next = 1'b0;
        end
        if (state_next == ST_WR_PULSE) begin
            we_n_next = 1'b0;
        end
        // Drive data only with output enable high, so the two never fight
        if (state_next == ST_WR_PULSE || state_next == ST_WR_HOLD) begin
            doe_next = wide_next ? lanes_next : 2'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_reg <= ST_IDLE;
            addr_reg <= '0;
            wdata_reg <= DATA_ZERO;
            lanes_reg <= 2'h0;
            wide_reg <= 1'b1;
            rdata_reg <= DATA_ZERO;
            done_reg <= 1'b0;
            ready_reg <= 1'b0;
            retain_reg <= 1'b0;
            sel_n_reg <= 1'b1;
            sel_h_reg <= 1'b0;
            we_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            lane_n_reg <= LANES_OFF_N;
            doe_reg <= 2'h0;
        end else begin
            state_reg <= state_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            lanes_reg <= lanes_next;
            wide_reg <= wide_next;
            rdata_reg <= rdata_next;
            done_reg <= done_next;
            ready_reg <= ready_next;
            retain_reg <= retain_next;
            sel_n_reg <= sel_n_next;
            sel_h_reg <= sel_h_next;
            we_n_reg <= we_n_next;
            oe_n_reg <= oe_n_next;
            lane_n_reg <= lane_n_next;
            doe_reg <= doe_next;
        end
    end

    // ==========================================================
    // Outputs
    assign ready_o = ready_reg;
    assign done_o = done_reg;
    assign rdata_o = rdata_reg;
    assign retain_ok_o = retain_reg;
    assign select_low_active_n_o = sel_n_reg;
    assign select_high_active_o = sel_h_reg;
    assign write_n_o = we_n_reg;
    assign out_en_n_o = oe_n_reg;
    assign upper_lane_n_o = lane_n_reg[1];
    assign lower_lane_n_o = lane_n_reg[0];
    assign addr_o = addr_reg[ADDR_W-1:0];
    assign extra_address_msb_o = addr_reg[ADDR_W];
    assign data_o = wdata_reg;
    assign data_oe_o = doe_reg;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    sequence seq_we_pulse;
        !write_n_o [*4] ##1 write_n_o;
    endsequence

    sequence seq_read_access;
        (!out_en_n_o && write_n_o) [*5] ##1 out_en_n_o;
    endsequence

    a_write_fully_enabled: assert property (
        !write_n_o |-> !select_low_active_n_o && select_high_active_o &&
            (!wide_reg || !(upper_lane_n_o && lower_lane_n_o)))
        else $error("write strobe low without full enables");

    a_write_pulse_width: assert property ($fell(write_n_o) |-> seq_we_pulse)
        else $error("write strobe pulse not four cycles");

    a_write_end_by_strobe: assert property (
        $rose(write_n_o) |-> !select_low_active_n_o && select_high_active_o && data_oe_o != 2'h0)
        else $error("write not ended by strobe with data held");

    a_read_access_time: assert property ($fell(out_en_n_o) |-> seq_read_access)
        else $error("read access not five cycles with strobe high");

    a_read_selected: assert property (
        !out_en_n_o |-> !select_low_active_n_o && select_high_active_o)
        else $error("output enable low while deselected");

    a_no_bus_fight: assert property (
        $rose(out_en_n_o) |-> (data_oe_o == 2'h0) [*2])
        else $error("data driven during output turnaround");

    a_byte_mode_lanes: assert property (
        !wide_reg && !select_low_active_n_o |->
            data_oe_o[1] == 1'b0 && !upper_lane_n_o && !lower_lane_n_o)
        else $error("upper lane used in byte mode");

    a_retain_deselected: assert property (
        retain_ok_o |-> select_low_active_n_o && !select_high_active_o && write_n_o)
        else $error("retention granted while selected");

    a_empty_write_skipped: assert property (
        ready_o && req_i && !retain_req_i && wide_mode_i && byte_en_i == 2'h0 |=>
            done_o && select_low_active_n_o && write_n_o)
        else $error("laneless request touched the memory");

endmodule

// ==== verification/asbp_sram_model.sv ====
// Behavioural model of the byte-lane asynchronous static memory
`timescale 1ns/1ps
module asbp_sram_model
    import asbp_pkg::*;
(
    // Memory pins
    input wire logic select_low_active_n_i,
    input wire logic select_high_active_i,
    input wire logic write_n_i,
    input wire logic out_en_n_i,
    input wire logic upper_lane_n_i,
    input wire logic lower_lane_n_i,
    input wire logic wide_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic extra_address_msb_i,
    input wire logic [DATA_W-1:0] bus_i,
    // Data drive
    output logic [DATA_W-1:0] data_o,
    output logic [1:0] oe_o
);
    // ==========
    // Storage; unwritten cells read as zero so the bench can predict them
    logic [DATA_W-1:0] word_mem [int];
    logic [LANE_W-1:0] byte_mem [int];
    logic sel;
    logic lanes_on;
    logic wr_act;
    logic rd_act;
    logic [DATA_W-1:0] wd;
    logic [1:0] wl_n;
    logic [ADDR_W:0] wa;

    assign sel = !select_low_active_n_i && select_high_active_i;
    assign lanes_on = !wide_i || !(upper_lane_n_i && lower_lane_n_i);
    assign wr_act = sel && lanes_on && !write_n_i;
    assign rd_act = sel && lanes_on && write_n_i && !out_en_n_i;

    // ==========
    // Write lands at the edge that ends it, with the last values seen inside it
    always @* begin
        if (wr_act) begin
            wd = bus_i;
            wl_n = {upper_lane_n_i, lower_lane_n_i};
            wa = {extra_address_msb_i, addr_i};
        end
    end

    always @(negedge wr_act) if (!$isunknown(wa)) begin
        if (!wide_i) begin
            byte_mem[wa] = wd[7:0];
        end else begin
            if (!word_mem.exists(wa[19:0])) word_mem[wa[19:0]] = 16'h0000;
            if (!wl_n[0]) word_mem[wa[19:0]][7:0] = wd[7:0];
            if (!wl_n[1]) word_mem[wa[19:0]][15:8] = wd[15:8];
        end
    end

    // ==========
    // Read drive per lane; byte mode uses only the low lane
    always @(rd_act or wr_act or addr_i or extra_address_msb_i or wide_i or upper_lane_n_i or lower_lane_n_i) begin
        if (wide_i) begin
            data_o = word_mem.exists(addr_i) ? word_mem[addr_i] : 16'h0000;
        end else begin
            data_o = 16'h0000;
            if (byte_mem.exists({extra_address_msb_i, addr_i})) begin
                data_o[7:0] = byte_mem[{extra_address_msb_i, addr_i}];
            end
        end
        oe_o = 2'h0;
        if (rd_act) oe_o = wide_i ? ~{upper_lane_n_i, lower_lane_n_i} : 2'h1;
    end
endmodule

// ==== verification/async_sram_byte_lane_port_tb_top.sv ====
// Self-checking bench for the asynchronous SRAM host controller
`timescale 1ns/1ps
module async_sram_byte_lane_port_tb_top
    import asbp_pkg::*;
();
    logic clk_i, reset_i, req_i, write_i, wide_mode_i, retain_req_i;
    logic [ADDR_W:0] addr_i;
    logic [DATA_W-1:0] wdata_i, rdata_o, data_o, mdl_d, last_bus;
    wire [DATA_W-1:0] data_i;
    logic [1:0] byte_en_i, data_oe_o, mdl_oe;
    logic ready_o, done_o, retain_ok_o, sl_n, sh, wr_n, oe_n, up_n, lo_n, xmsb;
    logic [ADDR_W-1:0] addr_o;
    logic [DATA_W-1:0] ref_w [int];
    logic [7:0] ref_b [int];
    int fail_count, cmp_count, n, i, m;

    asbp_host u_asbp_host (.clk_i(clk_i), .reset_i(reset_i), .req_i(req_i), .write_i(write_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .byte_en_i(byte_en_i), .wide_mode_i(wide_mode_i), .retain_req_i(retain_req_i),
        .ready_o(ready_o), .done_o(done_o), .rdata_o(rdata_o), .retain_ok_o(retain_ok_o),
        .select_low_active_n_o(sl_n), .select_high_active_o(sh), .write_n_o(wr_n), .out_en_n_o(oe_n),
        .upper_lane_n_o(up_n), .lower_lane_n_o(lo_n), .addr_o(addr_o), .extra_address_msb_o(xmsb),
        .data_o(data_o), .data_oe_o(data_oe_o), .data_i(data_i));
    asbp_sram_model u_asbp_sram_model (.select_low_active_n_i(sl_n), .select_high_active_i(sh), .write_n_i(wr_n),
        .out_en_n_i(oe_n), .upper_lane_n_i(up_n), .lower_lane_n_i(lo_n), .wide_i(wide_mode_i), .addr_i(addr_o),
        .extra_address_msb_i(xmsb), .bus_i(data_i), .data_o(mdl_d), .oe_o(mdl_oe));

    // ==========
    // Undriven lanes show a changing pattern, never a stale value
    assign data_i[7:0] = data_oe_o[0] ? data_o[7:0] : mdl_oe[0] ? mdl_d[7:0] : ~last_bus[7:0];
    assign data_i[15:8] = data_oe_o[1] ? data_o[15:8] : mdl_oe[1] ? mdl_d[15:8] : ~last_bus[15:8];
    always @(posedge clk_i) begin
        last_bus <= data_i;
        if (!reset_i) chk("lane clash", 16'h0, {14'h0, data_oe_o & mdl_oe});
    end
    always #5 clk_i = ~clk_i;

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    function automatic logic [15:0] exp_rd(logic [20:0] a, logic [1:0] be, logic wide);
        logic [15:0] w;
        if (!wide) return {8'h00, ref_b.exists(a) ? ref_b[a] : 8'h00};
        w = ref_w.exists(a[19:0]) ? ref_w[a[19:0]] : 16'h0000;
        return w & {{8{be[1]}}, {8{be[0]}}};
    endfunction

    task automatic op(input logic wr, input logic [20:0] a, input logic [15:0] d, input logic [1:0] be, input logic wide);
        logic [15:0] w;
        req_i <= 1'b1;
        write_i <= wr;
        addr_i <= a;
        wdata_i <= d;
        byte_en_i <= be;
        wide_mode_i <= wide;
        n = 0;
        do @(posedge clk_i); while (ready_o !== 1'b1 && n++ < 50);
        // Scramble the request after the take to catch unlatched fields
        req_i <= 1'b0;
        addr_i <= ~a;
        wdata_i <= ~d;
        n = 0;
        do begin @(posedge clk_i); n++; end while (done_o !== 1'b1 && n < 50);
        chk("done latency", (wide && be == 2'h0) ? 16'h1 : wr ? 16'h8 : 16'h6, 16'(n));
        if (!wr) begin
            chk("read data", exp_rd(a, be, wide), rdata_o);
        end else if (!wide) begin
            ref_b[a] = d[7:0];
        end else begin
            w = ref_w.exists(a[19:0]) ? ref_w[a[19:0]] : 16'h0000;
            if (be[0]) w[7:0] = d[7:0];
            if (be[1]) w[15:8] = d[15:8];
            ref_w[a[19:0]] = w;
        end
    endtask

    task automatic results();
        $display("counts: %0d compares, %0d mismatches", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        #100000;
        fail_count++;
        $display("test watchdog expired");
        results();
    end

    initial begin
        clk_i = 0; reset_i = 1; req_i = 0; write_i = 0; addr_i = '0; wdata_i = '0;
        byte_en_i = 2'h3; wide_mode_i = 1; retain_req_i = 0; last_bus = '0;
        n = $urandom(35);
        repeat (3) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        // Lanes written apart, laneless write must leave the word alone
        op(1, 21'h000005, 16'ha5c3, 2'h1, 1);
        op(1, 21'h000005, 16'h7e81, 2'h2, 1);
        op(1, 21'h000005, 16'hffff, 2'h0, 1);
        for (i = 0; i < 4; i++) op(0, 21'h000005, 16'h0, 2'(i), 1);
        $display("test lanes done");
        for (m = 0; m < 2; m++) begin
            for (i = 0; i < 40; i++) begin
                op(1'($urandom), 21'($urandom) & 21'h100007, 16'($urandom), 2'($urandom), m == 0);
            end
            $display("test random mode %0d done", m);
        end
        // Retention with a request that must be refused
        retain_req_i <= 1'b1;
        req_i <= 1'b1;
        byte_en_i <= 2'h3;
        wide_mode_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk("retain ok", 16'h1, {15'h0, retain_ok_o});
        chk("retain pins", 16'h000f, {11'h0, sh, sl_n, up_n, lo_n, oe_n});
        chk("refused done", 16'h0, {14'h0, done_o, ready_o});
        req_i <= 1'b0;
        retain_req_i <= 1'b0;
        n = 0;
        do @(posedge clk_i); while (ready_o !== 1'b1 && n++ < 20);
        chk("recovery cycles", 16'(REC_CYC + 1), 16'(n));
        op(0, 21'h000005, 16'h0, 2'h3, 1);
        $display("test retention done");
        results();
    end
endmodule
